// ---- dv/test_deep_sleep_port_clock_gating.sv ----
// Self-checking testbench for the deep-sleep port clock gating block (dpg_top).
// Assumes the design package dpg_pkg is compiled first; the bench acts as sole AHB-Lite master.
`timescale 1ns/100ps
`default_nettype none
module test_deep_sleep_port_clock_gating;
    import dpg_pkg::*;

    // Byte addresses of the gating, status and mask registers
    localparam logic [31:0] A_DEEP = 32'h400f_e128;
    localparam logic [31:0] A_STAT = 32'h400f_e130;
    localparam logic [31:0] A_MASK = 32'h400f_e134;

    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    dpg_port_t run_g;
    dpg_port_t sleep_g;
    logic auto_en;
    dpg_mode_e power_mode;
    dpg_port_req_s port_req;
    dpg_port_t port_clk_en;
    logic port_req_grant;
    logic port_req_fault;
    logic irq;
    int n_mismatch = 0;
    int n_tests = 0;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    dpg_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .run_port_clock_gate(run_g), .sleep_port_clock_gate(sleep_g),
        .auto_sleep_gating_enable(auto_en), .power_mode(power_mode), .port_req(port_req),
        .port_clk_en(port_clk_en), .port_req_grant(port_req_grant),
        .port_req_fault(port_req_fault), .irq(irq)
    );

    // 20 MHz bus clock
    always #25 hclk = ~hclk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // One single AHB-Lite transfer; waits on hready, never on a fixed latency
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        rd = hrdata;
        check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
    endtask : bus

    task automatic wr(input logic [31:0] addr, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, addr, d, unused);
    endtask : wr

    task automatic rd_chk(input string what, input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, d);
        check(what, d, exp);
    endtask : rd_chk

    // One access to port idx; the answer pulse stands in the following cycle
    task automatic poke(input int idx, input logic en);
        @(posedge hclk);
        port_req <= '{valid: 1'b1, idx: idx[2:0]};
        @(posedge hclk);
        port_req <= '{valid: 1'b0, idx: 3'h0};
        #1;
        check("grant", {31'h0, port_req_grant}, {31'h0, en});
        check("fault", {31'h0, port_req_fault}, {31'h0, ~en});
    endtask : poke

    task automatic t_reset();
        check("clk_en", {24'h0, port_clk_en}, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        rd_chk("deep", A_DEEP, 32'h0);
        rd_chk("status", A_STAT, 32'h0);
        rd_chk("mask", A_MASK, 32'h0);
    endtask : t_reset

    // Reserved bits written high must read back zero; each bit gates its own port
    task automatic t_deep_rw();
        logic [7:0] v;
        v = 8'ha5;
        @(posedge hclk);
        auto_en <= 1'b1;
        power_mode <= DPG_DEEP;
        wr(A_DEEP, 32'hffff_ffa5);
        rd_chk("deep", A_DEEP, 32'h0000_00a5);
        repeat (2) @(posedge hclk);
        #1;
        check("clk_en", {24'h0, port_clk_en}, 32'h0000_00a5);
        for (int i = 0; i < 8; i++) begin
            poke(i, v[i]);
        end
    endtask : t_deep_rw

    // Neighbouring offset and another page must not reach the gating register
    task automatic t_decode();
        wr(32'h400f_e118, 32'h0000_005a);
        wr(32'h500f_e128, 32'h0000_005a);
        rd_chk("deep", A_DEEP, 32'h0000_00a5);
        rd_chk("unmapped", 32'h400f_e118, 32'h0);
    endtask : t_decode

    // Every power mode, spare code too, with automatic gating on and off
    task automatic t_modes();
        dpg_port_t exp;
        dpg_mode_e m;
        @(posedge hclk);
        run_g <= 8'h3c;
        sleep_g <= 8'hc3;
        for (int a = 0; a < 2; a++) begin
            for (int k = 0; k < 4; k++) begin
                m = dpg_mode_e'(k);
                @(posedge hclk);
                auto_en <= a[0];
                power_mode <= m;
                repeat (3) @(posedge hclk);
                #1;
                exp = 8'h3c;
                if (a == 1 && m == DPG_SLEEP) exp = 8'hc3;
                if (a == 1 && m == DPG_DEEP) exp = 8'ha5;
                check("mode_en", {24'h0, port_clk_en}, {24'h0, exp});
            end
        end
    endtask : t_modes

    // Fault on a masked-out port stays silent, an unmasked one raises irq until read
    task automatic t_irq();
        logic [31:0] d;
        bus(1'b0, A_STAT, 32'h0, d);
        wr(A_MASK, 32'h0000_0002);
        rd_chk("mask", A_MASK, 32'h0000_0002);
        @(posedge hclk);
        run_g <= 8'h00;
        repeat (3) @(posedge hclk);
        poke(3, 1'b0);
        // Status takes the fault one edge after the pulse, irq with it
        @(posedge hclk);
        #1;
        check("irq_masked", {31'h0, irq}, 32'h0);
        poke(1, 1'b0);
        @(posedge hclk);
        #1;
        check("irq_set", {31'h0, irq}, 32'h1);
        rd_chk("status", A_STAT, 32'h0000_000a);
        @(posedge hclk);
        #1;
        check("irq_clr", {31'h0, irq}, 32'h0);
        rd_chk("status2", A_STAT, 32'h0);
    endtask : t_irq

    // A second reset in mid-run returns all ports to unclocked
    task automatic t_reset2();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("deep_rst", A_DEEP, 32'h0);
        rd_chk("mask_rst", A_MASK, 32'h0);
        repeat (2) @(posedge hclk);
        #1;
        check("clk_en_rst", {24'h0, port_clk_en}, 32'h0);
    endtask : t_reset2

    // Main sequence: all inputs set at time zero, reset held for 20 cycles
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        run_g = 8'h00;
        sleep_g = 8'h00;
        auto_en = 1'b0;
        power_mode = DPG_RUN;
        port_req = '{valid: 1'b0, idx: 3'h0};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_deep_rw();
        t_decode();
        t_modes();
        t_irq();
        t_reset2();
        stop_test();
    end

    // Watchdog well beyond the fewer than 150 cycles the run needs
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        stop_test();
    end

endmodule : test_deep_sleep_port_clock_gating
`default_nettype wire

// ---- logic/dpg_fault_chk.sv ----
// Checks each fabric access to a port unit against that port's clock enable.
// Assumes requests are single-cycle strobes synchronous to the bus clock.
`timescale 1ns/100ps
`default_nettype none
module dpg_fault_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire dpg_pkg::dpg_port_req_s port_req,
    input wire dpg_pkg::dpg_port_t port_clk_en,
    output logic port_req_grant,
    output logic port_req_fault,
    output dpg_pkg::dpg_port_t fault_event
);
    import dpg_pkg::*;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic target_on;
    assign target_on = port_clk_en[port_req.idx];

    // An access to an unclocked port never reaches it; it is answered with a fault
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_req_grant <= 1'b0;
            port_req_fault <= 1'b0;
            fault_event <= '0;
        end else begin
            port_req_grant <= port_req.valid && target_on;
            port_req_fault <= port_req.valid && !target_on;
            fault_event <= '0;
            if (port_req.valid && !target_on) begin
                fault_event[port_req.idx] <= 1'b1;
            end
        end
    end

    a_off_port_faults: assert property (
        (port_req.valid && !port_clk_en[port_req.idx])
            |=> port_req_fault && !port_req_grant && fault_event != '0)
        else $error("access to an unclocked port was not faulted");
    a_on_port_passes: assert property (
        (port_req.valid && port_clk_en[port_req.idx]) |=> port_req_grant && !port_req_fault)
        else $error("access to a clocked port was faulted");

endmodule : dpg_fault_chk
`default_nettype wire

// ---- logic/dpg_gate_sel.sv ----
// Per-port clock enable selection from the three gating sources.
// Assumes the power state and the run and sleep gating vectors come from the same clock.
`timescale 1ns/100ps
`default_nettype none
module dpg_gate_sel (
    input wire logic hclk,
    input wire logic hresetn,
    input wire dpg_pkg::dpg_mode_e power_mode,
    input wire logic auto_sleep_gating_enable,
    input wire dpg_pkg::dpg_port_t run_port_clock_gate,
    input wire dpg_pkg::dpg_port_t sleep_port_clock_gate,
    input wire dpg_pkg::dpg_port_t deep_sleep_port_clock_gate,
    output var dpg_pkg::dpg_port_t port_clk_en
);
    import dpg_pkg::*;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // One registered enable per port; a cleared enable stops the clock and holds the port off
    genvar gi;
    generate
        for (gi = 0; gi < PORT_N; gi++) begin : g_port
            logic en_next;
            always_comb begin
                if (!auto_sleep_gating_enable) begin
                    en_next = run_port_clock_gate[gi];
                end else begin
                    case (power_mode)
                        DPG_SLEEP: en_next = sleep_port_clock_gate[gi];
                        DPG_DEEP: en_next = deep_sleep_port_clock_gate[gi];
                        default: en_next = run_port_clock_gate[gi];
                    endcase
                end
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    port_clk_en[gi] <= 1'b0;
                end else begin
                    port_clk_en[gi] <= en_next;
                end
            end
        end
    endgenerate

    a_deep_follows_reg: assert property (
        (auto_sleep_gating_enable && power_mode == DPG_DEEP)
            |=> port_clk_en == $past(deep_sleep_port_clock_gate))
        else $error("deep-sleep enables do not follow the gating register");
    a_deep_bits_off: assert property (
        (auto_sleep_gating_enable && power_mode == DPG_DEEP)
            |=> (port_clk_en & ~$past(deep_sleep_port_clock_gate)) == '0)
        else $error("port clocked in deep sleep while its bit is clear");
    a_sleep_uses_own: assert property (
        (auto_sleep_gating_enable && power_mode == DPG_SLEEP)
            |=> port_clk_en == $past(sleep_port_clock_gate))
        else $error("sleep state does not use the sleep gating vector");
    a_no_auto_run: assert property (
        !auto_sleep_gating_enable |=> port_clk_en == $past(run_port_clock_gate))
        else $error("run gating not applied while automatic gating is off");

endmodule : dpg_gate_sel
`default_nettype wire

// ---- logic/dpg_pkg.sv ----
// Constants, types and register map for the deep-sleep port clock gating block.
// Assumes a single 20 MHz bus clock and an AHB-Lite master in front of the block.
package dpg_pkg;

    // Port count and per-port vector type; bit 0 is port A, bit 7 is port H
    localparam int unsigned PORT_N = 8;
    localparam int unsigned PORT_IDX_W = 3;
    typedef logic [PORT_N-1:0] dpg_port_t;

    // System control page and register offsets inside it
    localparam logic [19:0] DPG_BASE_PAGE = 20'h400fe;
    localparam logic [11:0] OFS_DEEP_GATE = 12'h128;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h130;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h134;

    // Reset values
    localparam dpg_port_t DEEP_GATE_RESET = 8'h00;
    localparam dpg_port_t IRQ_STATUS_RESET = 8'h00;
    localparam dpg_port_t IRQ_MASK_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [23:0] RESV_ZERO = 24'h00_0000;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Power state of the system as seen by the clock gates
    typedef enum logic [1:0] {
        DPG_RUN,
        DPG_SLEEP,
        DPG_DEEP
    } dpg_mode_e;

    // Access from the fabric towards one of the port units
    typedef struct packed {
        logic valid;
        logic [PORT_IDX_W-1:0] idx;
    } dpg_port_req_s;

    // Captured address phase of a bus transfer
    typedef struct packed {
        logic hit;
        logic write;
        logic [11:0] ofs;
    } dpg_bus_cmd_s;

endpackage : dpg_pkg

// ---- logic/dpg_top.sv ----
// Deep-sleep port clock gating: AHB-Lite register slave, port enable selection,
// fault answer for accesses to unclocked ports, and a fault interrupt.
// Assumes one 20 MHz clock, a single AHB-Lite master and run/sleep gating from elsewhere.
`timescale 1ns/100ps
`default_nettype none
module dpg_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire dpg_pkg::dpg_port_t run_port_clock_gate,
    input wire dpg_pkg::dpg_port_t sleep_port_clock_gate,
    input wire logic auto_sleep_gating_enable,
    input wire dpg_pkg::dpg_mode_e power_mode,
    input wire dpg_pkg::dpg_port_req_s port_req,
    output dpg_pkg::dpg_port_t port_clk_en,
    output logic port_req_grant,
    output logic port_req_fault,
    output logic irq
);
    import dpg_pkg::*;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    dpg_port_t deep_sleep_port_clock_gate_reg;
    dpg_port_t irq_status_reg;
    dpg_port_t irq_status_next;
    dpg_port_t irq_mask_reg;
    dpg_port_t fault_event;
    dpg_bus_cmd_s cmd;
    dpg_bus_cmd_s dphase_reg;
    logic accept;
    logic wr_gate;
    logic wr_mask;
    logic rd_status;
    logic [31:0] rdata_next;

    // Address phase decode; only the system control page is claimed by this block
    always_comb begin
        cmd.hit = (haddr[31:12] == DPG_BASE_PAGE);
        cmd.write = hwrite;
        cmd.ofs = haddr[11:0];
    end

    // A transfer is taken when selected, active and the previous one has finished
    assign accept = hsel && hready && htrans[1];

    // Remember the address phase so the write lands in the data phase with hwdata
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_reg <= '0;
        end else if (hready) begin
            dphase_reg <= accept ? cmd : '0;
        end
    end

    // Write strobes in the data phase
    assign wr_gate = dphase_reg.hit && dphase_reg.write
        && (dphase_reg.ofs == OFS_DEEP_GATE);
    assign wr_mask = dphase_reg.hit && dphase_reg.write && (dphase_reg.ofs == OFS_IRQ_MASK);

    // Deep-sleep gating register; bit n gates port n, A at bit 0 up to H at bit 7
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deep_sleep_port_clock_gate_reg <= DEEP_GATE_RESET;
        end else if (wr_gate) begin
            deep_sleep_port_clock_gate_reg <= hwdata[PORT_N-1:0];
        end
    end

    // Interrupt mask, same layout as the status bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_reg <= hwdata[PORT_N-1:0];
        end
    end

    // A read of the status register clears it; a fault in that same cycle survives
    assign rd_status = accept && !hwrite && cmd.hit && (cmd.ofs == OFS_IRQ_STATUS);
    always_comb begin
        irq_status_next = irq_status_reg;
        if (rd_status) begin
            irq_status_next = '0;
        end
        irq_status_next = irq_status_next | fault_event;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_reg <= IRQ_STATUS_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Level interrupt, registered so it never glitches on a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_next & irq_mask_next());
        end
    end

    // Mask value as it will be after this edge, so irq tracks mask writes without lag
    function automatic dpg_port_t irq_mask_next();
        return wr_mask ? hwdata[PORT_N-1:0] : irq_mask_reg;
    endfunction : irq_mask_next

    // Read data mux; a write still in its data phase is forwarded so back-to-back
    // write then read returns the new value. Reserved bits and unmapped words read zero.
    always_comb begin
        rdata_next = RDATA_RESET;
        if (cmd.hit) begin
            case (cmd.ofs)
                OFS_DEEP_GATE: begin
                    rdata_next = {RESV_ZERO, wr_gate ? hwdata[PORT_N-1:0]
                        : deep_sleep_port_clock_gate_reg};
                end
                OFS_IRQ_STATUS: begin
                    rdata_next = {RESV_ZERO, irq_status_reg};
                end
                OFS_IRQ_MASK: begin
                    rdata_next = {RESV_ZERO, irq_mask_next()};
                end
                default: begin
                    rdata_next = RDATA_RESET;
                end
            endcase
        end
    end

    // Read data is captured at the address phase edge and stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RDATA_RESET;
        end else if (accept && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

    // Zero wait states and always OKAY; faults to ports are signalled on their own path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // Effective per-port enables for the present power state
    dpg_gate_sel u_gate_sel (
        .hclk(hclk),
        .hresetn(hresetn),
        .power_mode(power_mode),
        .auto_sleep_gating_enable(auto_sleep_gating_enable),
        .run_port_clock_gate(run_port_clock_gate),
        .sleep_port_clock_gate(sleep_port_clock_gate),
        .deep_sleep_port_clock_gate(deep_sleep_port_clock_gate_reg),
        .port_clk_en(port_clk_en)
    );

    // Fault answer for accesses that target an unclocked port
    dpg_fault_chk u_fault_chk (
        .hclk(hclk),
        .hresetn(hresetn),
        .port_req(port_req),
        .port_clk_en(port_clk_en),
        .port_req_grant(port_req_grant),
        .port_req_fault(port_req_fault),
        .fault_event(fault_event)
    );

    // Write to the gating register: address phase, then data phase
    sequence s_gate_addr;
        accept && hwrite && cmd.hit && cmd.ofs == OFS_DEEP_GATE;
    endsequence

    sequence s_gate_read;
        accept && !hwrite && cmd.hit && cmd.ofs == OFS_DEEP_GATE;
    endsequence

    property p_gate_store;
        dpg_port_t d;
        (s_gate_addr ##1 (hready, d = hwdata[PORT_N-1:0])) |=> deep_sleep_port_clock_gate_reg == d;
    endproperty

    a_gate_bit_order: assert property (p_gate_store)
        else $error("gating register did not store write data in bit order");

    a_gate_resv_zero: assert property (
        s_gate_read |=> hrdata[31:PORT_N] == RESV_ZERO
            && hrdata[PORT_N-1:0] == $past(rdata_next[PORT_N-1:0]))
        else $error("gating register read returned reserved bits or stale data");

    a_gate_reset_zero: assert property (
        @(posedge hclk) $rose(hresetn) |-> deep_sleep_port_clock_gate_reg == DEEP_GATE_RESET
            && port_clk_en == '0)
        else $error("gating register not zero after reset");

    a_gate_decode_only: assert property (
        (dphase_reg.write && !(dphase_reg.hit && dphase_reg.ofs == OFS_DEEP_GATE))
            |=> $stable(deep_sleep_port_clock_gate_reg))
        else $error("gating register changed on a write to another address");

    a_deep_end_to_end: assert property (
        (auto_sleep_gating_enable && power_mode == DPG_DEEP && !wr_gate)
            ##1 (auto_sleep_gating_enable && power_mode == DPG_DEEP)
            |=> port_clk_en == $past(deep_sleep_port_clock_gate_reg))
        else $error("deep-sleep port enables do not match the gating register");

    a_status_sticky: assert property (
        (fault_event != '0) |=> (irq_status_reg & $past(fault_event)) == $past(fault_event))
        else $error("fault event lost from the status register");

    a_irq_level: assert property (
        irq == |($past(irq_status_next) & $past(irq_mask_next())) or $rose(hresetn))
        else $error("interrupt level disagrees with status and mask");

    a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("slave stalled or answered with an error");

    // Write to the interrupt mask: address phase, then data phase
    sequence s_mask_addr;
        accept && hwrite && cmd.hit && cmd.ofs == OFS_IRQ_MASK;
    endsequence

    sequence s_mask_read;
        accept && !hwrite && cmd.hit && cmd.ofs == OFS_IRQ_MASK;
    endsequence

    sequence s_status_read;
        accept && !hwrite && cmd.hit && cmd.ofs == OFS_IRQ_STATUS;
    endsequence

    // Any read that none of the three registers claims
    sequence s_other_read;
        accept && !hwrite && !(cmd.hit && (cmd.ofs == OFS_DEEP_GATE
            || cmd.ofs == OFS_IRQ_STATUS || cmd.ofs == OFS_IRQ_MASK));
    endsequence

    // Mask bits land in the same positions as the status bits
    property p_mask_store;
        dpg_port_t d;
        (s_mask_addr ##1 (hready, d = hwdata[PORT_N-1:0])) |=> irq_mask_reg == d;
    endproperty

    a_mask_bit_store: assert property (p_mask_store)
        else $error("mask register did not store write data");

    // The mask moves only on a data phase write to its own offset
    a_mask_hold: assert property (
        !wr_mask |=> $stable(irq_mask_reg))
        else $error("mask register changed without a write");

    // Plain read of the gating register, no write in flight to forward
    a_gate_rd_value: assert property (
        (s_gate_read ##0 !wr_gate)
            |=> hrdata == {RESV_ZERO, $past(deep_sleep_port_clock_gate_reg)})
        else $error("gating register read returned the wrong value");

    // Write still in its data phase is seen by the read right behind it
    a_gate_rd_forward: assert property (
        (s_gate_read ##0 wr_gate)
            |=> hrdata[PORT_N-1:0] == $past(hwdata[PORT_N-1:0]))
        else $error("read behind a gating write missed the new value");

    // The gating register moves only on a data phase write to its own offset
    a_gate_hold_idle: assert property (
        !wr_gate |=> $stable(deep_sleep_port_clock_gate_reg))
        else $error("gating register changed without a write");

    // A status read hands over the bits before the clear
    a_status_rd_data: assert property (
        s_status_read |=> hrdata == {RESV_ZERO, $past(irq_status_reg)})
        else $error("status read did not return the bits before the clear");

    // Only a fault arriving in the read cycle survives the clear
    a_status_rd_clear: assert property (
        s_status_read |=> irq_status_reg == $past(fault_event))
        else $error("status read did not clear the status register");

    // Plain mask read with no mask write in flight
    a_mask_rd_value: assert property (
        (s_mask_read ##0 !wr_mask) |=> hrdata == {RESV_ZERO, $past(irq_mask_reg)})
        else $error("mask register read returned the wrong value");

    // Unclaimed words read as zero, so software never sees stale bus data
    a_unmapped_zero: assert property (s_other_read |=> hrdata == RDATA_RESET)
        else $error("read of an unmapped address returned data");

    // Read data stands until the next read is taken
    a_rdata_stands: assert property (
        !(accept && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a new read");

    // With every port masked the interrupt stays low whatever the status holds
    a_irq_masked_off: assert property (
        (irq_mask_reg == '0 && !wr_mask) |=> !irq)
        else $error("interrupt raised with all sources masked");

    // An unmasked fault raises the interrupt on the following edge
    a_irq_on_fault: assert property (
        ((fault_event & irq_mask_reg) != '0 && !wr_mask) |=> irq)
        else $error("unmasked fault did not raise the interrupt");

    // Zero wait states: every taken transfer ends its data phase at the next edge
    a_zero_wait: assert property (accept |=> hreadyout && hresp == HRESP_OKAY)
        else $error("taken transfer was stretched or failed");

    // A port access is either granted or faulted, never both
    a_grant_or_fault: assert property (!(port_req_grant && port_req_fault))
        else $error("port access both granted and faulted");

    // An unclocked port never sees a granted access
    a_off_no_grant: assert property (
        (port_req.valid && !port_clk_en[port_req.idx]) |=> !port_req_grant)
        else $error("unclocked port was granted an access");

endmodule : dpg_top
`default_nettype wire
